// *** rtl/radio_modem_afc_config_bank.sv ***
// Purpose: Modem, frequency-correction and I/Q phase configuration bank
//          with the correction loop sequencing it steers.
// Assumes: Plain register port on clk; read data valid the cycle after the
//          read strobe only. Receiver event inputs come from logic on clk.
// Notes:   Decoded outputs follow a register write after two clocks; afcActive and afcLocked follow a mode write after three.
//
// Summary of operation
// R1: Bandwidth field selects 100/150/200/300 kHz.
// R2: Widest bandwidth moves IF to 300 kHz.
// R3: Modulation codes: FSK, GFSK, carrier; others reserved.
// R4: Only demodulation code zero is accepted.
// R5: Mode zero: loop free-running, never locks.
// R6: Mode one: correction loop switched off.
// R7: Mode two: loop paused, correction frozen.
// R8: Mode three: lock on preamble, or on sync only while preambleMatchZero is set.
// R9: Proportional gain is two to field power.
// R10: Integral gain is two to field power.
// R11: Phase trim seven bits; top bit zero.
// R12: Software writes fixed mode-register fields correctly.
// R13: Software never programs reserved codes.
`timescale 1ns/1ps
`default_nettype none

module radio_modem_afc_config_bank
  import radio_afc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  // Receiver events
  input wire logic preambleDetect,
  input wire logic syncDetect,
  input wire logic preambleMatchZero,
  input wire logic rxRestart,
  // Frequency error samples
  input wire logic freqErrValid,
  input wire logic [ERR_W-1:0] freqError,
  // Receiver settings
  output logic [KHZ_W-1:0] ifBandwidthKhz,
  output logic [KHZ_W-1:0] ifFreqKhz,
  output logic demodEnable,
  output logic [PHASE_W-1:0] iqPhaseTrim,
  // Transmitter settings
  output logic txFskEnable,
  output logic txGaussian,
  output logic txCarrierOnly,
  // Correction loop
  output logic afcActive,
  output logic afcLocked,
  output logic [ACC_W-1:0] freqCorrection
);

  // ==========================================================================
  // Stored registers
  logic [DATA_W-1:0] receiver_modem_config;
  logic [DATA_W-1:0] freq_correction_mode;
  logic [DATA_W-1:0] freq_correction_gains;
  logic [PHASE_W-1:0] iq_phase_trim;
  logic [DATA_W-1:0] next_receiver_modem_config;
  logic [DATA_W-1:0] next_freq_correction_mode;
  logic [DATA_W-1:0] next_freq_correction_gains;
  logic [PHASE_W-1:0] next_iq_phase_trim;
  logic [DATA_W-1:0] next_rdData;

  logic [RX_FILTER_BANDWIDTH_SEL_W-1:0] rx_filter_bandwidth_sel;
  logic [TXMOD_W-1:0] tx_modulation_sel;
  logic [DEMOD_W-1:0] rx_demodulation_sel;
  logic [MODESEL_W-1:0] freq_correction_mode_sel;
  logic [GAIN_W-1:0] freq_correction_prop_gain;
  logic [GAIN_W-1:0] freq_correction_integ_gain;

  afc_ctrl_if ctl ();

  assign rx_filter_bandwidth_sel =
    receiver_modem_config[RX_FILTER_BANDWIDTH_SEL_POS +: RX_FILTER_BANDWIDTH_SEL_W];
  assign tx_modulation_sel = receiver_modem_config[TXMOD_POS +: TXMOD_W];
  assign rx_demodulation_sel = receiver_modem_config[DEMOD_POS +: DEMOD_W];
  assign freq_correction_mode_sel =
    freq_correction_mode[MODESEL_POS +: MODESEL_W];
  assign freq_correction_prop_gain = freq_correction_gains[KP_POS +: GAIN_W];
  assign freq_correction_integ_gain =
    freq_correction_gains[KI_POS +: GAIN_W];

  // The fixed mode-register fields are stored and read back as written; the
  // loop ignores them, so a wrong value is visible to software only.
  assign ctl.modeSel = afc_mode_t'(freq_correction_mode_sel); // R12
  assign ctl.propGain = freq_correction_prop_gain; // R9
  assign ctl.integGain = freq_correction_integ_gain; // R10

  // ==========================================================================
  // Register writes and read data
  always_comb begin
    next_receiver_modem_config = receiver_modem_config;
    next_freq_correction_mode = freq_correction_mode;
    next_freq_correction_gains = freq_correction_gains;
    next_iq_phase_trim = iq_phase_trim;
    next_rdData = '0;
    if (wrStrobe) begin
      case (addr)
        OFF_MODEM: next_receiver_modem_config = wrData;
        OFF_MODE: next_freq_correction_mode = wrData;
        OFF_GAINS: next_freq_correction_gains = wrData;
        // The reserved top bit is not kept, so it always reads zero.
        OFF_PHASE: next_iq_phase_trim = wrData[PHASE_W-1:0]; // R11
        default: ;
      endcase
    end
    if (rdStrobe) begin
      case (addr)
        OFF_MODEM: next_rdData = receiver_modem_config;
        OFF_MODE: next_rdData = freq_correction_mode;
        OFF_GAINS: next_rdData = freq_correction_gains;
        OFF_PHASE: next_rdData = {1'b0, iq_phase_trim}; // R11
        OFF_STATUS: next_rdData = {5'h00, afcActive, ctl.state};
        OFF_CORR: next_rdData = freqCorrection[CORR_HI_POS +: DATA_W];
        default: next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      receiver_modem_config <= RST_MODEM;
      freq_correction_mode <= RST_MODE;
      freq_correction_gains <= RST_GAINS;
      iq_phase_trim <= RST_PHASE;
      rdData <= '0;
    end else begin
      receiver_modem_config <= next_receiver_modem_config;
      freq_correction_mode <= next_freq_correction_mode;
      freq_correction_gains <= next_freq_correction_gains;
      iq_phase_trim <= next_iq_phase_trim;
      rdData <= next_rdData;
    end
  end

  // ==========================================================================
  // Decoded settings
  logic [KHZ_W-1:0] next_ifBandwidthKhz;
  logic [KHZ_W-1:0] next_ifFreqKhz;
  logic next_demodEnable;
  logic next_txFskEnable;
  logic next_txGaussian;
  logic next_txCarrierOnly;
  logic next_afcActive;
  logic next_afcLocked;

  always_comb begin
    case (rx_filter_bandwidth_sel)
      2'h0: next_ifBandwidthKhz = BW_KHZ_100; // R1
      2'h1: next_ifBandwidthKhz = BW_KHZ_150; // R1
      2'h2: next_ifBandwidthKhz = BW_KHZ_200; // R1
      default: next_ifBandwidthKhz = BW_KHZ_300; // R1
    endcase
    // No write is needed for the IF move; it tracks the bandwidth field.
    next_ifFreqKhz = (rx_filter_bandwidth_sel == RX_FILTER_BANDWIDTH_SEL_WIDEST) ?
      IF_KHZ_WIDE : IF_KHZ_NORMAL; // R2
    // Reserved codes leave the transmitter with no modulation selected.
    next_txFskEnable = 1'b0;
    next_txGaussian = 1'b0;
    next_txCarrierOnly = 1'b0;
    case (tx_modulation_sel)
      TXMOD_FSK: next_txFskEnable = 1'b1; // R3
      TXMOD_GFSK: begin
        next_txFskEnable = 1'b1; // R3
        next_txGaussian = 1'b1; // R3
      end
      TXMOD_CARRIER: next_txCarrierOnly = 1'b1; // R3
      default: ; // R13
    endcase
    // A reserved demodulation code keeps the demodulator idle.
    next_demodEnable = (rx_demodulation_sel == DEMOD_COMMON); // R4
    next_afcActive = ctl.runLoop;
    next_afcLocked = (ctl.state == AFC_LOCKED); // R8
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ifBandwidthKhz <= BW_KHZ_100;
      ifFreqKhz <= IF_KHZ_NORMAL;
      demodEnable <= 1'b1;
      iqPhaseTrim <= RST_PHASE;
      txFskEnable <= 1'b1;
      txGaussian <= 1'b0;
      txCarrierOnly <= 1'b0;
      afcActive <= 1'b0;
      afcLocked <= 1'b0;
    end else begin
      ifBandwidthKhz <= next_ifBandwidthKhz;
      ifFreqKhz <= next_ifFreqKhz;
      demodEnable <= next_demodEnable;
      iqPhaseTrim <= iq_phase_trim; // R11
      txFskEnable <= next_txFskEnable;
      txGaussian <= next_txGaussian;
      txCarrierOnly <= next_txCarrierOnly;
      afcActive <= next_afcActive;
      afcLocked <= next_afcLocked;
    end
  end

  // ==========================================================================
  // Correction loop
  afc_mode_fsm modeSeq (
    .clk(clk),
    .reset_n(reset_n),
    .ctl(ctl.fsm),
    .preambleDetect(preambleDetect),
    .syncDetect(syncDetect),
    .preambleMatchZero(preambleMatchZero),
    .rxRestart(rxRestart)
  );

  afc_pi_loop piLoop (
    .clk(clk),
    .reset_n(reset_n),
    .ctl(ctl.loop),
    .freqErrValid(freqErrValid),
    .freqError(freqError),
    .correction(freqCorrection)
  );

  // ==========================================================================
  // Checks
  property p_bw_150;
    @(posedge clk) disable iff (!reset_n)
    (rx_filter_bandwidth_sel == 2'h1) |=> (ifBandwidthKhz == BW_KHZ_150);
  endproperty
  a_bw_150: assert property (p_bw_150) // R1
    else $error("bandwidth code one did not give 150 kHz");

  property p_bw_write;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && (addr == OFF_MODEM) && (wrData[RX_FILTER_BANDWIDTH_SEL_POS +: RX_FILTER_BANDWIDTH_SEL_W] == 2'h0)
      |=> ##1 (ifBandwidthKhz == BW_KHZ_100);
  endproperty
  a_bw_write: assert property (p_bw_write) // R1
    else $error("bandwidth code zero did not give 100 kHz");

  property p_if_follows_bw;
    @(posedge clk) disable iff (!reset_n)
    (ifBandwidthKhz == BW_KHZ_300) == (ifFreqKhz == IF_KHZ_WIDE);
  endproperty
  a_if_follows_bw: assert property (p_if_follows_bw) // R2
    else $error("IF frequency does not match the bandwidth");

  property p_carrier_only;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && (addr == OFF_MODEM)
      && (wrData[TXMOD_POS +: TXMOD_W] == TXMOD_CARRIER)
      |=> ##1 txCarrierOnly && !txFskEnable && !txGaussian;
  endproperty
  a_carrier_only: assert property (p_carrier_only) // R3
    else $error("carrier code did not select an unmodulated carrier");

  property p_demod_reserved;
    @(posedge clk) disable iff (!reset_n)
    (rx_demodulation_sel != DEMOD_COMMON) |=> !demodEnable;
  endproperty
  a_demod_reserved: assert property (p_demod_reserved) // R4
    else $error("reserved demodulation code enabled the demodulator");

  property p_prop_gain;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && (addr == OFF_GAINS)
      |=> (ctl.propGain == $past(wrData[KP_POS +: GAIN_W]));
  endproperty
  a_prop_gain: assert property (p_prop_gain) // R9
    else $error("proportional gain did not follow the write");

  property p_integ_gain;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && (addr == OFF_GAINS)
      |=> (ctl.integGain == $past(wrData[KI_POS +: GAIN_W]));
  endproperty
  a_integ_gain: assert property (p_integ_gain) // R10
    else $error("integral gain did not follow the write");

  property p_phase_readback;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && (addr == OFF_PHASE) ##1 rdStrobe && (addr == OFF_PHASE)
      |=> (rdData == {1'b0, $past(wrData[PHASE_W-1:0], 2)});
  endproperty
  a_phase_readback: assert property (p_phase_readback) // R11
    else $error("phase trim readback wrong or top bit set");

  property p_locked_flag;
    @(posedge clk) disable iff (!reset_n)
    (ctl.state == AFC_LOCKED) |=> afcLocked && !afcActive;
  endproperty
  a_locked_flag: assert property (p_locked_flag) // R8
    else $error("locked state not shown on afcLocked");

endmodule // radio_modem_afc_config_bank

`default_nettype wire

// *** rtl/radio_afc_pkg.sv ***
// Purpose: Shared constants and types of the modem and frequency-correction
//          configuration bank.
// Assumes: One 25 MHz clock, synchronous active-low reset.
// Notes:   Offsets are the register addresses seen on the plain register port.
`default_nettype none

package radio_afc_pkg;

  // ==========================================================================
  // Register port and map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MODEM = 12'h115;
  localparam logic [ADDR_W-1:0] OFF_MODE = 12'h116;
  localparam logic [ADDR_W-1:0] OFF_GAINS = 12'h117;
  localparam logic [ADDR_W-1:0] OFF_PHASE = 12'h118;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h1f0;
  localparam logic [ADDR_W-1:0] OFF_CORR = 12'h1f1;

  // ==========================================================================
  // Field positions and widths
  localparam int RX_FILTER_BANDWIDTH_SEL_POS = 6;
  localparam int RX_FILTER_BANDWIDTH_SEL_W = 2;
  localparam int TXMOD_POS = 3;
  localparam int TXMOD_W = 3;
  localparam int DEMOD_POS = 0;
  localparam int DEMOD_W = 3;
  localparam int MODESEL_POS = 0;
  localparam int MODESEL_W = 2;
  localparam int KP_POS = 4;
  localparam int KI_POS = 0;
  localparam int GAIN_W = 4;
  localparam int PHASE_W = 7;

  // ==========================================================================
  // Values after reset
  localparam logic [DATA_W-1:0] RST_MODEM = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODE = 8'h08;
  localparam logic [DATA_W-1:0] RST_GAINS = 8'h37;
  localparam logic [PHASE_W-1:0] RST_PHASE = 7'h00;

  // ==========================================================================
  // Codes and decoded values
  localparam int KHZ_W = 9;
  localparam logic [KHZ_W-1:0] BW_KHZ_100 = 9'h064;
  localparam logic [KHZ_W-1:0] BW_KHZ_150 = 9'h096;
  localparam logic [KHZ_W-1:0] BW_KHZ_200 = 9'h0c8;
  localparam logic [KHZ_W-1:0] BW_KHZ_300 = 9'h12c;
  localparam logic [KHZ_W-1:0] IF_KHZ_NORMAL = 9'h0c8;
  localparam logic [KHZ_W-1:0] IF_KHZ_WIDE = 9'h12c;
  localparam logic [RX_FILTER_BANDWIDTH_SEL_W-1:0] RX_FILTER_BANDWIDTH_SEL_WIDEST = 2'h3;
  localparam logic [TXMOD_W-1:0] TXMOD_FSK = 3'h0;
  localparam logic [TXMOD_W-1:0] TXMOD_GFSK = 3'h1;
  localparam logic [TXMOD_W-1:0] TXMOD_CARRIER = 3'h3;
  localparam logic [DEMOD_W-1:0] DEMOD_COMMON = 3'h0;

  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_OFF = 2'h1,
    MODE_HOLD = 2'h2,
    MODE_LOCK = 2'h3
  } afc_mode_t;

  // Gray order along off, run, locked, hold.
  typedef enum logic [1:0] {
    AFC_OFF = 2'h0,
    AFC_RUN = 2'h1,
    AFC_LOCKED = 2'h3,
    AFC_HOLD = 2'h2
  } afc_state_t;

  // ==========================================================================
  // Correction loop arithmetic
  localparam int ERR_W = 8;
  localparam int ACC_W = 28;
  localparam int CORR_HI_POS = 20;

endpackage

`default_nettype wire

// *** rtl/afc_ctrl_if.sv ***
// Purpose: Control bundle between the register bank, the mode sequencer and
//          the correction loop.
// Assumes: All members change on clk of the bank.
// Notes:   No clocking block; pure wiring.
`timescale 1ns/1ps
`default_nettype none

interface afc_ctrl_if
  import radio_afc_pkg::*;
  ();
  afc_mode_t modeSel;
  logic [GAIN_W-1:0] propGain;
  logic [GAIN_W-1:0] integGain;
  afc_state_t state;
  logic runLoop;
  logic clearLoop;

  modport bank (output modeSel, output propGain, output integGain,
                input state);
  modport fsm (input modeSel, output state, output runLoop,
               output clearLoop);
  modport loop (input propGain, input integGain, input runLoop,
                input clearLoop);
endinterface

`default_nettype wire

// *** rtl/afc_mode_fsm.sv ***
// Purpose: Sequencer of the frequency-correction loop mode.
// Assumes: Detect inputs are one-cycle pulses on clk.
// Notes:   Locked state is left by a mode change or rxRestart.
`timescale 1ns/1ps
`default_nettype none

module afc_mode_fsm
  import radio_afc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control bundle
  afc_ctrl_if.fsm ctl,
  // Receiver events
  input wire logic preambleDetect,
  input wire logic syncDetect,
  input wire logic preambleMatchZero,
  input wire logic rxRestart
);

  afc_state_t state;
  afc_state_t next_state;
  logic lockHit;

  // A sync word may only lock when preamble matching is exact.
  assign lockHit = preambleDetect || (syncDetect && preambleMatchZero); // R8

  always_comb begin
    next_state = state;
    case (ctl.modeSel)
      MODE_FREE: next_state = AFC_RUN; // R5
      MODE_OFF: next_state = AFC_OFF; // R6
      MODE_HOLD: next_state = AFC_HOLD; // R7
      MODE_LOCK: begin
        case (state)
          AFC_RUN: next_state = lockHit ? AFC_LOCKED : AFC_RUN; // R8
          AFC_LOCKED: next_state = rxRestart ? AFC_RUN : AFC_LOCKED;
          default: next_state = AFC_RUN;
        endcase
      end
      default: next_state = AFC_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= AFC_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign ctl.state = state;
  assign ctl.runLoop = (state == AFC_RUN);
  assign ctl.clearLoop = (state == AFC_OFF);

  // ==========================================================================
  // Checks
  // The check looks one cycle later so that the edge that releases reset,
  // where the state is still off, cannot fire it.
  property p_free_never_locks;
    @(posedge clk) disable iff (!reset_n)
    (ctl.modeSel == MODE_FREE) ##1 (ctl.modeSel == MODE_FREE)
      |=> (state == AFC_RUN) && !(state == AFC_LOCKED);
  endproperty
  a_free_never_locks: assert property (p_free_never_locks) // R5
    else $error("free-running mode reached a non-running state");

  property p_off_clears;
    @(posedge clk) disable iff (!reset_n)
    (ctl.modeSel == MODE_OFF) |=> ctl.clearLoop && !ctl.runLoop;
  endproperty
  a_off_clears: assert property (p_off_clears) // R6
    else $error("off mode did not stop the loop");

  property p_lock_on_hit;
    @(posedge clk) disable iff (!reset_n)
    (ctl.modeSel == MODE_LOCK) && (state == AFC_RUN) && lockHit
      |=> (state == AFC_LOCKED) && !ctl.runLoop;
  endproperty
  a_lock_on_hit: assert property (p_lock_on_hit) // R8
    else $error("lock mode missed a preamble or sync event");

  property p_sync_needs_match;
    @(posedge clk) disable iff (!reset_n)
    (ctl.modeSel == MODE_LOCK) && (state == AFC_RUN) && !preambleDetect
      && !preambleMatchZero |=> (state != AFC_LOCKED);
  endproperty
  a_sync_needs_match: assert property (p_sync_needs_match) // R8
    else $error("locked on sync word with nonzero preamble match");

endmodule // afc_mode_fsm

`default_nettype wire

// *** rtl/afc_pi_loop.sv ***
// Purpose: Proportional-integral frequency-correction accumulator.
// Assumes: freqError is a signed offset sample, valid with freqErrValid.
// Notes:   Sums wrap at ACC_W bits; large gains with large errors overflow.
`timescale 1ns/1ps
`default_nettype none

module afc_pi_loop
  import radio_afc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control bundle
  afc_ctrl_if.loop ctl,
  // Error samples
  input wire logic freqErrValid,
  input wire logic [ERR_W-1:0] freqError,
  // Correction
  output logic [ACC_W-1:0] correction
);

  logic [ACC_W-1:0] integ;
  logic [ACC_W-1:0] next_integ;
  logic [ACC_W-1:0] next_correction;
  logic [ACC_W-1:0] errExt;
  logic [ACC_W-1:0] integStep;

  assign errExt = {{(ACC_W-ERR_W){freqError[ERR_W-1]}}, freqError};
  assign integStep = integ + (errExt << ctl.integGain); // R10

  always_comb begin
    next_integ = integ;
    next_correction = correction;
    if (ctl.clearLoop) begin
      next_integ = '0; // R6
      next_correction = '0; // R6
    end else if (ctl.runLoop && freqErrValid) begin
      next_integ = integStep;
      next_correction = integStep + (errExt << ctl.propGain); // R9
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      integ <= '0;
      correction <= '0;
    end else begin
      integ <= next_integ;
      correction <= next_correction;
    end
  end

  // ==========================================================================
  // Checks
  property p_frozen_when_paused;
    @(posedge clk) disable iff (!reset_n)
    !ctl.runLoop && !ctl.clearLoop |=> $stable(correction) && $stable(integ);
  endproperty
  a_frozen_when_paused: assert property (p_frozen_when_paused) // R7
    else $error("correction moved while the loop was paused");

  property p_off_zero;
    @(posedge clk) disable iff (!reset_n)
    ctl.clearLoop |=> (correction == '0) && (integ == '0);
  endproperty
  a_off_zero: assert property (p_off_zero) // R6
    else $error("correction not zero with the loop off");

endmodule // afc_pi_loop

`default_nettype wire

// *** sim/test_radio_modem_afc_config_bank.sv ***
// Purpose: Self-checking bench of the modem and correction config bank.
// Assumes: Plain register port; read data only in the cycle after rdStrobe.
// Notes:   Outputs are compared with a small integer model of the rules.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin numChecks++; \
  if ((gt) !== (ex)) begin failCount++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module test_radio_modem_afc_config_bank
  import radio_afc_pkg::*;
;
  // ==========================================================================
  // Design connections
  logic clk, reset_n, wrStrobe, rdStrobe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData, d, q;
  logic [2:0] exTx;
  logic [KHZ_W-1:0] exIf;
  logic preambleDetect, syncDetect, preambleMatchZero, rxRestart;
  logic freqErrValid, demodEnable, txFskEnable, txGaussian, txCarrierOnly;
  logic [ERR_W-1:0] freqError;
  logic [KHZ_W-1:0] ifBandwidthKhz, ifFreqKhz;
  logic [PHASE_W-1:0] iqPhaseTrim;
  logic afcActive, afcLocked;
  logic [ACC_W-1:0] freqCorrection, integ, corr, ext;
  int failCount = 0, numChecks = 0, kp, ki;

  radio_modem_afc_config_bank dut_u (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .preambleDetect(preambleDetect),
    .syncDetect(syncDetect), .preambleMatchZero(preambleMatchZero),
    .rxRestart(rxRestart), .freqErrValid(freqErrValid),
    .freqError(freqError), .ifBandwidthKhz(ifBandwidthKhz),
    .ifFreqKhz(ifFreqKhz), .demodEnable(demodEnable),
    .iqPhaseTrim(iqPhaseTrim), .txFskEnable(txFskEnable),
    .txGaussian(txGaussian), .txCarrierOnly(txCarrierOnly),
    .afcActive(afcActive), .afcLocked(afcLocked),
    .freqCorrection(freqCorrection));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Bus and event tasks
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk) begin addr <= a; wrData <= v; wrStrobe <= 1'b1; end
    @(posedge clk) wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk) begin addr <= a; rdStrobe <= 1'b1; end
    @(posedge clk) rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask

  // Write, then read the same address with no gap between the strobes.
  task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                      output logic [7:0] r);
    @(posedge clk) begin addr <= a; wrData <= v; wrStrobe <= 1'b1; end
    @(posedge clk) begin wrStrobe <= 1'b0; rdStrobe <= 1'b1; end
    @(posedge clk) rdStrobe <= 1'b0;
    #1 r = rdData;
  endtask

  // Pulse {preamble, sync, restart, valid} for one cycle, then let it settle.
  task automatic ev(input logic [3:0] v, input logic [7:0] e);
    @(posedge clk) begin
      {preambleDetect, syncDetect, rxRestart, freqErrValid} <= v;
      freqError <= e;
    end
    @(posedge clk) begin
      {preambleDetect, syncDetect, rxRestart, freqErrValid} <= 4'h0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic mode(input logic [1:0] m);
    wr(OFF_MODE, 8'h08 | {6'h00, m});
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic sample(input logic upd);
    logic [7:0] e;
    e = 8'($urandom);
    ev(4'h1, e);
    ext = {{20{e[7]}}, e};
    if (upd) begin
      integ = integ + (ext << ki);
      corr = integ + (ext << kp);
    end
    `CHK("correction", corr, freqCorrection)
  endtask

  function automatic logic [KHZ_W-1:0] bwk(input logic [1:0] c);
    case (c)
      2'h0: return BW_KHZ_100;
      2'h1: return BW_KHZ_150;
      2'h2: return BW_KHZ_200;
      default: return BW_KHZ_300;
    endcase
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the whole run needs about 1200 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    final_report();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    reset_n = 1'b0; addr = '0; wrData = '0; wrStrobe = 1'b0; rdStrobe = 1'b0;
    preambleDetect = 1'b0; syncDetect = 1'b0; preambleMatchZero = 1'b0;
    rxRestart = 1'b0; freqErrValid = 1'b0; freqError = '0;
    void'($urandom(72));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("active", 1'b1, afcActive)
    rd(OFF_MODEM, d);
    `CHK("rst modem", RST_MODEM, d)
    rd(OFF_MODE, d);
    `CHK("rst mode", RST_MODE, d)
    rd(OFF_GAINS, d);
    `CHK("rst gains", RST_GAINS, d)
    rd(OFF_PHASE, d);
    `CHK("rst phase", 8'h00, d)
    $display("reset test done");

    for (int i = 0; i < 256; i++) begin
      wr(OFF_MODEM, 8'(i));
      rd(OFF_MODEM, d);
      `CHK("modem rb", 8'(i), d)
      `CHK("bw", bwk(d[7:6]), ifBandwidthKhz)
      exIf = (d[7:6] == 2'h3) ? IF_KHZ_WIDE : IF_KHZ_NORMAL;
      `CHK("if", exIf, ifFreqKhz)
      exTx = {d[5:4] == 2'h0, d[5:3] == 3'h1, d[5:3] == 3'h3};
      `CHK("tx", exTx, {txFskEnable, txGaussian, txCarrierOnly})
      `CHK("demod", d[2:0] == 3'h0, demodEnable)
    end
    $display("modem test done");

    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wrrd(OFF_PHASE, d, q);
      `CHK("phase rb", {1'b0, d[6:0]}, q)
      `CHK("phase out", d[6:0], iqPhaseTrim)
    end
    wr(12'h119, 8'h5a);
    rd(12'h119, d); `CHK("unmapped", 8'h00, d)
    @(posedge clk) #1 `CHK("rd idle", 8'h00, rdData)
    $display("phase test done");

    kp = int'($urandom_range(15));
    ki = int'($urandom_range(15));
    wr(OFF_GAINS, {kp[3:0], ki[3:0]});
    rd(OFF_GAINS, d); `CHK("gains rb", {kp[3:0], ki[3:0]}, d)
    integ = '0;
    corr = '0;
    repeat (6) sample(1'b1);
    wr(OFF_STATUS, 8'hff);
    rd(OFF_STATUS, d);
    `CHK("status run", {5'h00, 1'b1, 2'h1}, d)
    wr(OFF_CORR, 8'hff);
    rd(OFF_CORR, d);
    `CHK("corr hi", corr[CORR_HI_POS +: DATA_W], d)
    ev(4'h8, 8'h00); `CHK("free lock", 1'b0, afcLocked)
    mode(2'h2); `CHK("hold act", 1'b0, afcActive)
    sample(1'b0);
    mode(2'h3); `CHK("lock run", 1'b1, afcActive)
    ev(4'h4, 8'h00); `CHK("sync pm", 1'b0, afcLocked)
    @(posedge clk) preambleMatchZero <= 1'b1;
    ev(4'h4, 8'h00); `CHK("sync lock", 1'b1, afcLocked)
    `CHK("lock act", 1'b0, afcActive)
    rd(OFF_STATUS, d);
    `CHK("status lock", {5'h00, 1'b0, 2'h3}, d)
    sample(1'b0);
    ev(4'h2, 8'h00); `CHK("restart", 1'b1, afcActive)
    @(posedge clk) preambleMatchZero <= 1'b0;
    ev(4'h8, 8'h00); `CHK("pre lock", 1'b1, afcLocked)
    ev(4'h2, 8'h00);
    sample(1'b1);
    mode(2'h1); `CHK("off act", 1'b0, afcActive)
    `CHK("off corr", 28'h0, freqCorrection)
    mode(2'h0);
    integ = '0;
    corr = '0;
    repeat (3) sample(1'b1);
    $display("loop test done");
    final_report();
  end
endmodule // test_radio_modem_afc_config_bank

`default_nettype wire
